// file: fpm_top.sv
// flash program memory access: registers, unlock, read and self-timed ops
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fpm_params.svh"
// Overview of operation
// - config select steers accesses to ID space
// - user IDs writable; device, revision, config read-only
// - unlisted config read returns zero word
// - low data byte: eight bits, kept across resets
// - high data byte: six bits, kept across resets
// - high data bits 7-6 read zero
// - low address byte read/write, reset zero
// - high address: seven bits, bit 7 reads one
// - read trigger fetches in one cycle, self-clears
module fpm_top
	import fpm_pkg::*;
#(
	parameter int          MEM_WORDS   = `FPM_MEM_WORDS,
	parameter int          ROW_WORDS   = `FPM_ROW_WORDS,
	parameter int          PROG_CYCLES = `FPM_PROG_CYCLES,
	// identity values below are arbitrary
	parameter logic [13:0] DEV_ID      = `FPM_DEV_ID,
	parameter logic [13:0] REV_ID      = `FPM_REV_ID,
	parameter logic [13:0] CFG1_VAL    = `FPM_CFG1_VAL,
	parameter logic [13:0] CFG2_VAL    = `FPM_CFG2_VAL
)
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// lite bus write channels
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// lite bus read channels
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	localparam int MI = $clog2(MEM_WORDS);
	localparam int LW = $clog2(ROW_WORDS);
	localparam int UIDS = 4;

	// refuse sizes the address map and latch row cannot serve
	if (MEM_WORDS < ROW_WORDS || MEM_WORDS > 32768 ||
		(1 << LW) != ROW_WORDS || ROW_WORDS < UIDS ||
		(1 << MI) != MEM_WORDS || PROG_CYCLES < 1 ||
		PROG_CYCLES > 65535)
	begin : g_bad_params
		$error("fpm_top: unsupported size parameters");
	end

	fpm_wr_t     wr;
	logic [31:0] rd_data;
	logic [7:0]  datl_q, datl_d, adrl_q, adrl_d;
	logic [5:0]  dath_q, dath_d;
	logic [6:0]  adrh_q, adrh_d;
	fpm_ctrl_t   ctl_q, ctl_d;
	fpm_unl_t    unl_q, unl_d;
	fpm_op_t     op_q, op_d;
	logic [15:0] cnt_q, cnt_d;
	logic        latch_we, row_prog, row_erase, cfg_prog, cfg_erase;
	logic [14:0] waddr;
	logic [14:0] rd_word;

	// storage: program array, row write latches, user ID words
	logic [13:0] mem_q [MEM_WORDS];
	logic [13:0] latch_q [ROW_WORDS];
	logic [13:0] uid_q [UIDS];

	assign waddr = {adrh_q, adrl_q};

	// bus slave front end
	fpm_axil u_axil (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr_o      (wr),
		.rd_data   (rd_data)
	);

	// config space word: bit 14 says the address is readable
	function automatic logic [14:0] cfg_read(input logic [14:0] a);
		logic [14:0] r;
		r = '0;
		if (a[14:4] == '0)
		begin
			if (a[3:0] <= `FPM_CFG_UID_LAST)
				r = {1'b1, uid_q[a[1:0]]};
			else if (a[3:0] == `FPM_CFG_REV)
				r = {1'b1, REV_ID};
			else if (a[3:0] == `FPM_CFG_DEV)
				r = {1'b1, DEV_ID};
			else if (a[3:0] == `FPM_CFG_WORD1)
				r = {1'b1, CFG1_VAL};
			else if (a[3:0] == `FPM_CFG_WORD2)
				r = {1'b1, CFG2_VAL};
		end
		return r;
	endfunction

	// program array index of word i in the addressed row
	function automatic logic [MI-1:0] row_idx(input int i);
		return {waddr[MI-1:LW], LW'(i)};
	endfunction

	// word fetched by the read trigger
	always_comb
	begin
		rd_word = '0;
		if (ctl_q.config_space_select)
			rd_word = cfg_read(waddr);
		else
			rd_word = {1'b1, mem_q[waddr[MI-1:0]]};
	end

	// register read mux; the unlock register is write-only
	always_comb
	begin
		rd_data = '0;
		case (s_araddr)
			`FPM_OFF_DATL: rd_data[7:0] = datl_q;
			`FPM_OFF_DATH: rd_data[7:0] = {2'h0, dath_q};
			`FPM_OFF_ADRL: rd_data[7:0] = adrl_q;
			`FPM_OFF_ADRH: rd_data[7:0] = {`FPM_UNIMPL_ONE, adrh_q};
			`FPM_OFF_CTRL: rd_data[7:0] = {`FPM_UNIMPL_ONE, ctl_q};
			default:       rd_data = '0;
		endcase
	end

	// register writes, read trigger, unlock tracking and timed operations
	always_comb
	begin
		datl_d = datl_q;
		dath_d = dath_q;
		adrl_d = adrl_q;
		adrh_d = adrh_q;
		ctl_d = ctl_q;
		unl_d = unl_q;
		op_d = op_q;
		cnt_d = cnt_q;
		latch_we = 1'b0;
		row_prog = 1'b0;
		row_erase = 1'b0;
		cfg_prog = 1'b0;
		cfg_erase = 1'b0;
		// fetch lands one cycle after the trigger was set
		if (ctl_q.rd)
		begin
			if (rd_word[14])
				{dath_d, datl_d} = rd_word[13:0];
			else
				{dath_d, datl_d} = '0;
			ctl_d.rd = 1'b0;
		end
		if (wr.en && wr.strb)
		begin
			case (wr.addr)
				`FPM_OFF_DATL: datl_d = wr.data;
				`FPM_OFF_DATH: dath_d = wr.data[5:0];
				`FPM_OFF_ADRL: adrl_d = wr.data;
				`FPM_OFF_ADRH: adrh_d = wr.data[6:0];
				`FPM_OFF_CTRL:
				begin
					// mode bits are frozen while an operation runs
					if (op_q == OP_IDLE)
					begin
						ctl_d.config_space_select = wr.data[`FPM_CTL_CONFIG_SPACE_SELECT];
						ctl_d.lwlo = wr.data[`FPM_CTL_LWLO];
						ctl_d.free = wr.data[`FPM_CTL_FREE];
						ctl_d.wren = wr.data[`FPM_CTL_WREN];
						ctl_d.wrerr = wr.data[`FPM_CTL_WRERR];
						// triggers can only be set, never cleared
						if (wr.data[`FPM_CTL_RD])
							ctl_d.rd = 1'b1;
						if (wr.data[`FPM_CTL_WR] && !ctl_q.wr)
						begin
							if (unl_q == UNL_ARMED && ctl_q.wren)
							begin
								ctl_d.wr = 1'b1;
								ctl_d.wrerr = 1'b1;
								op_d = OP_BUSY;
								// a latch-only load needs no flash time
								cnt_d = (ctl_d.lwlo && !ctl_d.free) ? '0
									: 16'(PROG_CYCLES - 1);
								latch_we = !ctl_d.free;
							end
							else
								ctl_d.wrerr = 1'b1;
						end
					end
				end
				default: ;
			endcase
		end
		// unlock pattern must be the two writes right before the trigger
		if (wr.en)
		begin
			if (wr.addr == `FPM_OFF_UNLK && wr.strb &&
				wr.data == `FPM_UNLOCK_FIRST)
				unl_d = UNL_GOT_FIRST;
			else if (wr.addr == `FPM_OFF_UNLK && wr.strb &&
				wr.data == `FPM_UNLOCK_SECOND && unl_q == UNL_GOT_FIRST)
				unl_d = UNL_ARMED;
			else
				unl_d = UNL_IDLE;
		end
		// self-timed operation ends and the write trigger clears in the same cycle
		case (op_q)
			OP_IDLE: ;
			OP_BUSY:
			begin
				if (cnt_q == '0)
				begin
					op_d = OP_IDLE;
					ctl_d.wr = 1'b0;
					ctl_d.wrerr = 1'b0;
					if (ctl_q.free)
					begin
						ctl_d.free = 1'b0;
						row_erase = !ctl_q.config_space_select;
						cfg_erase = ctl_q.config_space_select;
					end
					else if (!ctl_q.lwlo)
					begin
						row_prog = !ctl_q.config_space_select;
						cfg_prog = ctl_q.config_space_select;
					end
				end
				else
					cnt_d = cnt_q - 16'h0001;
			end
			default: op_d = OP_IDLE;
		endcase
	end

	// control state; data bytes keep their value through reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			adrl_q <= '0;
			adrh_q <= '0;
			ctl_q <= '0;
			unl_q <= UNL_IDLE;
			op_q <= OP_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			adrl_q <= adrl_d;
			adrh_q <= adrh_d;
			ctl_q <= ctl_d;
			unl_q <= unl_d;
			op_q <= op_d;
			cnt_q <= cnt_d;
		end
		datl_q <= datl_d;
		dath_q <= dath_d;
	end

	// array updates; only user ID words are ever written in config space
	always_ff @(posedge aclk)
	begin
		if (latch_we)
			latch_q[waddr[LW-1:0]] <= {dath_q, datl_q};
		for (int i = 0; i < ROW_WORDS; i++)
		begin
			if (row_erase)
				mem_q[row_idx(i)] <= `FPM_ERASED;
			else if (row_prog)
				mem_q[row_idx(i)] <= latch_q[i];
			// latches return to erased once the row is written
			if (row_prog || cfg_prog)
				latch_q[i] <= `FPM_ERASED;
		end
		for (int k = 0; k < UIDS; k++)
		begin
			if (cfg_erase && waddr[14:2] == '0)
				uid_q[k] <= `FPM_ERASED;
			else if (cfg_prog && waddr[14:2] == '0)
				uid_q[k] <= latch_q[k];
		end
	end
endmodule

// file: fpm_params.svh
// constants for the flash program memory access block
`ifndef FPM_PARAMS_SVH
`define FPM_PARAMS_SVH

// register byte offsets on the lite bus
`define FPM_OFF_DATL      8'h00
`define FPM_OFF_DATH      8'h04
`define FPM_OFF_ADRL      8'h08
`define FPM_OFF_ADRH      8'h0C
`define FPM_OFF_CTRL      8'h10
`define FPM_OFF_UNLK      8'h14

// bus responses
`define FPM_RESP_OKAY     2'h0
`define FPM_RESP_SLVERR   2'h2

// control byte field positions
`define FPM_CTL_RD        0
`define FPM_CTL_WR        1
`define FPM_CTL_WREN      2
`define FPM_CTL_WRERR     3
`define FPM_CTL_FREE      4
`define FPM_CTL_LWLO      5
`define FPM_CTL_CONFIG_SPACE_SELECT      6

// unlock pattern bytes
`define FPM_UNLOCK_FIRST  8'h55
`define FPM_UNLOCK_SECOND 8'hAA

// configuration space word indices
`define FPM_CFG_UID_LAST  4'h3
`define FPM_CFG_REV       4'h5
`define FPM_CFG_DEV       4'h6
`define FPM_CFG_WORD1     4'h7
`define FPM_CFG_WORD2     4'h8

// values and sizes
`define FPM_ERASED        14'h3FFF
`define FPM_UNIMPL_ONE    1'h1
`define FPM_MEM_WORDS     2048
`define FPM_ROW_WORDS     16
`define FPM_PROG_CYCLES   20
`define FPM_DEV_ID        14'h0123
`define FPM_REV_ID        14'h0001
`define FPM_CFG1_VAL      14'h3FFF
`define FPM_CFG2_VAL      14'h3FFF

`endif

// file: fpm_pkg.sv
// types shared by the flash program memory access block
`include "fpm_params.svh"
package fpm_pkg;

	// one register write taken from the bus
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
		logic       strb;
	} fpm_wr_t;

	// control byte, msb first: select, latch-only, erase, error, enable,
	// write trigger, read trigger
	typedef struct packed {
		logic config_space_select;
		logic lwlo;
		logic free;
		logic wrerr;
		logic wren;
		logic wr;
		logic rd;
	} fpm_ctrl_t;

	typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_FIRST, UNL_ARMED} fpm_unl_t;
	typedef enum logic {OP_IDLE, OP_BUSY} fpm_op_t;

	// true for any register offset that the block decodes
	function automatic logic fpm_mapped(input logic [7:0] a);
		return a == `FPM_OFF_DATL || a == `FPM_OFF_DATH ||
			a == `FPM_OFF_ADRL || a == `FPM_OFF_ADRH ||
			a == `FPM_OFF_CTRL || a == `FPM_OFF_UNLK;
	endfunction

endpackage

// file: fpm_axil.sv
// lite bus slave front end for the flash access registers
`timescale 1ns/1ps
`include "fpm_params.svh"
module fpm_axil
	import fpm_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address and data
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	// write response
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// read address and data
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// register side
	output fpm_wr_t          wr_o,
	input  wire logic [31:0] rd_data
);
	logic        awr_q, awr_d, wr_rdy_q, wr_rdy_d, bv_q, bv_d;
	logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic        arr_q, arr_d, rv_q, rv_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0]  awaddr_q, awaddr_d, wdata_q, wdata_d;
	logic        wstrb_q, wstrb_d;
	logic [31:0] rdata_q, rdata_d;
	fpm_wr_t     wr_q, wr_d;

	// address and data are taken in either order, held until both are in
	always_comb
	begin
		awr_d = awr_q;
		wr_rdy_d = wr_rdy_q;
		bv_d = bv_q;
		bresp_d = bresp_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		wr_d = '0;
		if (s_awvalid && awr_q)
		begin
			aw_have_d = 1'b1;
			awaddr_d = s_awaddr;
			awr_d = 1'b0;
		end
		if (s_wvalid && wr_rdy_q)
		begin
			w_have_d = 1'b1;
			wdata_d = s_wdata[7:0];
			wstrb_d = s_wstrb[0];
			wr_rdy_d = 1'b0;
		end
		if (aw_have_q && w_have_q && !bv_q)
		begin
			wr_d = '{en: 1'b1, addr: awaddr_q, data: wdata_q, strb: wstrb_q};
			bv_d = 1'b1;
			bresp_d = fpm_mapped(awaddr_q) ? `FPM_RESP_OKAY
				: `FPM_RESP_SLVERR;
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
		end
		// reopen both channels only once the response is gone
		if (bv_q && s_bready)
		begin
			bv_d = 1'b0;
			awr_d = 1'b1;
			wr_rdy_d = 1'b1;
		end
	end

	// read answers one cycle after the address is taken
	always_comb
	begin
		arr_d = arr_q;
		rv_d = rv_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_arvalid && arr_q)
		begin
			arr_d = 1'b0;
			rv_d = 1'b1;
			rdata_d = rd_data;
			rresp_d = fpm_mapped(s_araddr) ? `FPM_RESP_OKAY
				: `FPM_RESP_SLVERR;
		end
		if (rv_q && s_rready)
		begin
			rv_d = 1'b0;
			arr_d = 1'b1;
		end
	end

	// bus state registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awr_q <= 1'b1;
			wr_rdy_q <= 1'b1;
			bv_q <= 1'b0;
			bresp_q <= `FPM_RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= 1'b0;
			wr_q <= '0;
			arr_q <= 1'b1;
			rv_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `FPM_RESP_OKAY;
		end
		else
		begin
			awr_q <= awr_d;
			wr_rdy_q <= wr_rdy_d;
			bv_q <= bv_d;
			bresp_q <= bresp_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			wr_q <= wr_d;
			arr_q <= arr_d;
			rv_q <= rv_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_awready = awr_q;
	assign s_wready = wr_rdy_q;
	assign s_bvalid = bv_q;
	assign s_bresp = bresp_q;
	assign s_arready = arr_q;
	assign s_rvalid = rv_q;
	assign s_rdata = rdata_q;
	assign s_rresp = rresp_q;
	assign wr_o = wr_q;
endmodule

// file: fpm_sva.sv
// bus-level assertions for the flash access block
`timescale 1ns/1ps
`include "fpm_params.svh"
module fpm_sva
	import fpm_pkg::*;
(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// write channels
	input wire logic [7:0]  s_awaddr,
	input wire logic        s_awvalid,
	input wire logic        s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0]  s_wstrb,
	input wire logic        s_wvalid,
	input wire logic        s_wready,
	input wire logic [1:0]  s_bresp,
	input wire logic        s_bvalid,
	input wire logic        s_bready,
	// read channels
	input wire logic [7:0]  s_araddr,
	input wire logic        s_arvalid,
	input wire logic        s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0]  s_rresp,
	input wire logic        s_rvalid,
	input wire logic        s_rready
);
	logic [7:0] ar_q;
	logic [7:0] ar_d;

	// keep the read address, the reply only shows up a cycle later
	always_comb
	begin
		ar_d = ar_q;
		if (s_arvalid && s_arready)
			ar_d = s_araddr;
	end
	always_ff @(posedge aclk)
		ar_q <= ar_d;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	upper_zero_a:
	assert property (s_rvalid |-> s_rdata[31:8] == 24'h000000)
	else $error("read data upper lanes not zero");
	dath_top_a:
	assert property (s_rvalid && ar_q == `FPM_OFF_DATH |-> !s_rdata[7:6])
	else $error("data high bits 7-6 not zero");
	adrh_top_a:
	assert property (s_rvalid && ar_q == `FPM_OFF_ADRH |-> s_rdata[7])
	else $error("address high bit 7 not one");
	unmapped_rd_a:
	assert property (s_rvalid && (ar_q > `FPM_OFF_UNLK || ar_q[1:0] != 2'h0)
		|-> s_rresp == `FPM_RESP_SLVERR && s_rdata == 32'h00000000)
	else $error("unmapped read not refused");
	r_hold_a:
	assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
	else $error("read reply dropped before taken");
	b_hold_a:
	assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
	else $error("write reply dropped before taken");
	ar_answer_a:
	assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
	else $error("read not answered next cycle");
	wr_answer_a:
	assert property (s_awvalid && s_awready && s_wvalid && s_wready
		|-> ##[1:2] s_bvalid)
	else $error("write not answered in time");
	b_block_a:
	assert property (s_bvalid |-> !s_awready && !s_wready)
	else $error("write channels open while reply pending");
endmodule

bind fpm_top fpm_sva u_fpm_sva (.aclk, .aresetn, .s_awaddr, .s_awvalid,
	.s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
	.s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
	.s_rresp, .s_rvalid, .s_rready);

// file: tb_top.sv
// self-checking bench for the flash access block
`timescale 1ns/1ps
`include "fpm_params.svh"
module tb_top;
	// compare two values, count and report
	`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
		n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
	// identity values are arbitrary
	localparam logic [13:0] DEV = 14'h01A5;
	localparam logic [13:0] REV = 14'h002C;
	localparam logic [13:0] CF1 = 14'h2A5A;
	localparam logic [13:0] CF2 = 14'h15A5;
	localparam logic [7:0]  DL  = `FPM_OFF_DATL;
	localparam logic [7:0]  DH  = `FPM_OFF_DATH;
	localparam logic [7:0]  AL  = `FPM_OFF_ADRL;
	localparam logic [7:0]  AH  = `FPM_OFF_ADRH;
	localparam logic [7:0]  CT  = `FPM_OFF_CTRL;
	localparam logic [7:0]  UL  = `FPM_OFF_UNLK;
	localparam logic [1:0]  OK  = `FPM_RESP_OKAY;
	localparam logic [1:0]  SE  = `FPM_RESP_SLVERR;

	logic        aclk       = 1'b0;
	logic        aresetn    = 1'b0;
	logic [7:0]  s_awaddr   = 8'h00;
	logic        s_awvalid  = 1'b0;
	logic        s_awready;
	logic [31:0] s_wdata    = 32'h00000000;
	logic [3:0]  s_wstrb    = 4'hF;
	logic        s_wvalid   = 1'b0;
	logic        s_wready;
	logic [1:0]  s_bresp;
	logic        s_bvalid;
	logic        s_bready   = 1'b0;
	logic [7:0]  s_araddr   = 8'h00;
	logic        s_arvalid  = 1'b0;
	logic        s_arready;
	logic [31:0] s_rdata;
	logic [1:0]  s_rresp;
	logic        s_rvalid;
	logic        s_rready   = 1'b0;
	int          n_fail     = 0;
	int          num_checks = 0;

	// short op time keeps polling loops brief
	fpm_top #(.PROG_CYCLES(2), .DEV_ID(DEV), .REV_ID(REV), .CFG1_VAL(CF1),
		.CFG2_VAL(CF2)) u_fpm_top (.aclk, .aresetn, .s_awaddr, .s_awvalid,
		.s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
		.s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
		.s_rresp, .s_rvalid, .s_rready);

	initial
		forever #50 aclk = ~aclk;

	task automatic conclude;
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic rst;
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	// ready goes up with the request; one idle edge separates transfers
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er = OK);
		s_awaddr <= a;
		s_wdata <= {24'h000000, d};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_awready)
				s_awvalid <= 1'b0;
			if (s_wready)
				s_wvalid <= 1'b0;
		end
		while (!s_bvalid);
		`CHK(s_bresp, er)
		s_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		input logic [1:0] er = OK);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_arready)
				s_arvalid <= 1'b0;
		end
		while (!s_rvalid);
		d = s_rdata[7:0];
		`CHK(s_rresp, er)
		s_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e,
		input logic [1:0] er = OK);
		logic [7:0] v;
		rd(a, v, er);
		`CHK(v, e)
	endtask

	// run one unlocked write or erase in mode m, then fetch the word back
	task automatic prog(input logic [7:0] a, input logic [13:0] w,
		input logic [7:0] m);
		logic [7:0] v;
		wr(AH, 8'h00);
		wr(AL, a);
		wr(DL, w[7:0]);
		wr(DH, {2'h0, w[13:8]});
		wr(CT, m);
		wr(UL, `FPM_UNLOCK_FIRST);
		wr(UL, `FPM_UNLOCK_SECOND);
		wr(CT, m | 8'h02);
		do
			rd(CT, v);
		while (v[1]);
		`CHK(v, 8'h80 | (m & 8'h64))
		wr(DL, 8'h00);
		wr(DH, 8'h00);
		wr(CT, (m & 8'h40) | 8'h05);
	endtask

	task automatic t_regs;
		rc(AL, 8'h00);
		rc(AH, 8'h80);
		wr(DL, 8'hA5);
		rc(DL, 8'hA5);
		// a write with the low strobe clear must leave the byte alone
		s_wstrb <= 4'hE;
		wr(DL, 8'h00);
		s_wstrb <= 4'hF;
		rc(DL, 8'hA5);
		wr(DH, 8'hFF);
		rc(DH, 8'h3F);
		wr(AH, 8'hFF);
		rc(AH, 8'hFF);
		wr(AL, 8'hC3);
		rc(AL, 8'hC3);
		wr(8'h18, 8'h00, SE);
		rc(8'h18, 8'h00, SE);
		// a second reset must keep data bytes but clear the address
		rst();
		rc(DL, 8'hA5);
		rc(DH, 8'h3F);
		rc(AL, 8'h00);
		rc(AH, 8'h80);
	endtask

	task automatic t_cfg;
		logic [8:0] ad [7] = '{9'h004, 9'h005, 9'h006, 9'h007, 9'h008,
			9'h009, 9'h105};
		logic [13:0] ex [7] = '{14'h0000, REV, DEV, CF1, CF2, 14'h0000,
			14'h0000};
		for (int i = 0; i < 7; i++)
		begin
			wr(AH, {7'h00, ad[i][8]});
			wr(AL, ad[i][7:0]);
			wr(CT, 8'h41);
			rc(CT, 8'hC0);
			rc(DL, ex[i][7:0]);
			rc(DH, {2'h0, ex[i][13:8]});
		end
	endtask

	task automatic t_prog;
		prog(8'h01, 14'h2B5A, 8'h44);
		rc(DL, 8'h5A);
		rc(DH, 8'h2B);
		prog(8'h06, 14'h0000, 8'h44);
		rc(DL, DEV[7:0]);
		rc(DH, {2'h0, DEV[13:8]});
		// trigger without unlock is refused and raises the error flag
		wr(CT, 8'h46);
		rc(CT, 8'hCC);
	endtask

	// erase a row, load one latch alone, then program the row with another
	task automatic t_row;
		prog(8'h20, 14'h0000, 8'h14);
		rc(DL, 8'hFF);
		rc(DH, 8'h3F);
		prog(8'h24, 14'h0ABC, 8'h24);
		rc(DL, 8'hFF);
		prog(8'h25, 14'h1234, 8'h04);
		rc(DL, 8'h34);
		rc(DH, 8'h12);
		wr(AL, 8'h24);
		wr(CT, 8'h05);
		rc(DL, 8'hBC);
		rc(DH, 8'h0A);
	endtask

	initial
	begin
		rst();
		t_regs();
		t_cfg();
		t_prog();
		t_row();
		conclude();
	end

	// the whole sequence needs well under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		conclude();
	end
endmodule
